// ===== hw/sbl_layer1_fsm.sv
// Layer-1 activation and deactivation machine, terminal side
`timescale 1ns/1ps
`default_nettype none
module sbl_layer1_fsm import sbl_pkg::*; #(
  parameter int CLOCK_STOP_CYCLES = SBL_STOP_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic software_layer1_select,
  input wire logic [2:0] xcvr_command_reg,
  output logic [3:0] xcvr_status_reg,
  input wire logic [3:0] ci_cmd_reg,
  output logic [3:0] ci_ind_reg,
  output logic irq_status_reg,
  input wire logic irq_clear,
  output logic ci_change_irq,
  input wire logic rx_info0,
  input wire logic rx_info2,
  input wire logic rx_info4,
  input wire logic rx_infox,
  input wire logic frame_locked_flag,
  input wire logic rx_code_violation,
  input wire logic line_awake,
  input wire logic bit_tick,
  input wire logic clock_stop_cfg,
  input wire logic illegal_violation_enable,
  input wire logic loop_internal,
  output logic [2:0] tx_info,
  output logic tx_data_bit,
  output logic tx_pulse,
  output logic tx_pulse_neg,
  output logic loop_a_close,
  output logic transparent_en,
  output logic clocks_run,
  output logic analog_sleep_bit
);
  localparam int CW = $clog2(CLOCK_STOP_CYCLES + 1);
  localparam logic [CW-1:0] STOP_LAST = CW'(CLOCK_STOP_CYCLES - 1);
  localparam logic [5:0] FRAME_LAST = 6'(SBL_BITS_PER_FRAME - 1);

  // A zero delay would underflow the stop counter
  if (CLOCK_STOP_CYCLES < 1) begin : g_bad_stop
    $error("CLOCK_STOP_CYCLES must be at least one");
  end
  function automatic logic is_uncond(input logic [3:0] c);
    is_uncond = (c == SBL_CMD_RESTART) || (c == SBL_CMD_LOOP_ACT) ||
                (c == SBL_CMD_SINGLE_PULSE) || (c == SBL_CMD_CONT_PULSE);
  endfunction : is_uncond
  sbl_state_t state_reg, state_next, uncond_state;
  logic [3:0] ci_ind_next, state_ind, pend_ind_reg, pend_ind_next;
  logic prio10_reg, prio10_next;
  logic cvr_reg, cvr_next;
  logic [CW-1:0] stop_cnt_reg;
  logic stopped_reg;
  logic [2:0] pat_idx_reg;
  logic [5:0] bit_cnt_reg;
  logic [2:0] tx_info_next;
  logic state_change;
  // Decoded commands
  wire logic cmd_ar8 = (ci_cmd_reg == SBL_CMD_ACT_PRIO8);
  wire logic cmd_activate_prio10_cmd = (ci_cmd_reg == SBL_CMD_ACT_PRIO10);
  wire logic cmd_ar = cmd_ar8 || cmd_activate_prio10_cmd;
  wire logic cmd_di = (ci_cmd_reg == SBL_CMD_DEACT_IND);
  wire logic cmd_wake = (ci_cmd_reg == SBL_CMD_CLOCK_WAKE);
  wire logic cmd_uncond = is_uncond(ci_cmd_reg);
  wire logic in_test = (state_reg == SBL_ST_TEST_SINGLE) || (state_reg == SBL_ST_TEST_CONT);
  wire logic is_test_cmd = (ci_cmd_reg == SBL_CMD_SINGLE_PULSE) ||
                           (ci_cmd_reg == SBL_CMD_CONT_PULSE);
  wire logic in_loop = (state_reg == SBL_ST_LOOP_CLOSED) || (state_reg == SBL_ST_LOOP_ACTIVE);
  // Level commands: only act when entering, and test never hops straight to test
  wire logic uncond_hit = cmd_uncond && !(in_test && is_test_cmd) &&
                          !(in_loop && ci_cmd_reg == SBL_CMD_LOOP_ACT) &&
                          (state_reg != uncond_state);
  always_comb begin
    case (ci_cmd_reg)
      SBL_CMD_LOOP_ACT: uncond_state = SBL_ST_LOOP_CLOSED;
      SBL_CMD_SINGLE_PULSE: uncond_state = SBL_ST_TEST_SINGLE;
      SBL_CMD_CONT_PULSE: uncond_state = SBL_ST_TEST_CONT;
      default: uncond_state = SBL_ST_RESTART;
    endcase
  end
  always_comb begin
    state_next = state_reg;
    pend_ind_next = pend_ind_reg;
    prio10_next = cmd_ar ? cmd_activate_prio10_cmd : prio10_reg;
    if (software_layer1_select) begin
      state_next = SBL_ST_DEACT;
    end else if (uncond_hit) begin
      state_next = uncond_state;
    end else begin
      case (state_reg)
        SBL_ST_DEACT, SBL_ST_PWR_UP, SBL_ST_PEND_ACT: begin
          if (rx_info4) begin
            state_next = SBL_ST_ACTIVE;
          end else if (rx_info2) begin
            state_next = SBL_ST_SYNCED;
          end else if (rx_infox) begin
            state_next = SBL_ST_UNSYNC;
          end else if (cmd_ar && state_reg != SBL_ST_PEND_ACT) begin
            state_next = SBL_ST_PEND_ACT;
          end else if (cmd_wake && state_reg == SBL_ST_DEACT) begin
            state_next = SBL_ST_PWR_UP;
          end else if (cmd_di && state_reg != SBL_ST_DEACT) begin
            state_next = SBL_ST_DEACT;
          end
        end
        SBL_ST_UNSYNC: begin
          if (rx_info4) begin
            state_next = SBL_ST_ACTIVE;
          end else if (rx_info2) begin
            state_next = SBL_ST_SYNCED;
          end else if (cmd_di) begin
            state_next = SBL_ST_DEACT;
          end
        end
        SBL_ST_SYNCED, SBL_ST_ACTIVE, SBL_ST_LOST_FRAME: begin
          if (rx_info0) begin
            state_next = SBL_ST_PEND_DEACT;
            pend_ind_next = (state_reg == SBL_ST_SYNCED) ? SBL_IND_DEACT_FROM_SYNC
                                                         : SBL_IND_REMOTE_DEACT;
          end else if (!frame_locked_flag && state_reg != SBL_ST_LOST_FRAME) begin
            state_next = SBL_ST_LOST_FRAME;
          end else if (frame_locked_flag && rx_info4) begin
            state_next = SBL_ST_ACTIVE;
          end else if (frame_locked_flag && rx_info2) begin
            state_next = SBL_ST_SYNCED;
          end
        end
        SBL_ST_PEND_DEACT: begin
          if (cmd_di) begin
            state_next = SBL_ST_DEACT;
          end
        end
        SBL_ST_LOOP_CLOSED: begin
          if (frame_locked_flag) begin
            state_next = SBL_ST_LOOP_ACTIVE;
          end else if (cmd_di) begin
            state_next = SBL_ST_DEACT;
          end
        end
        SBL_ST_LOOP_ACTIVE, SBL_ST_TEST_SINGLE, SBL_ST_TEST_CONT, SBL_ST_RESTART: begin
          if (cmd_di) begin
            state_next = SBL_ST_DEACT;
          end
        end
        default: state_next = SBL_ST_DEACT;
      endcase
    end
  end

  // Indication and line signal per state
  always_comb begin
    state_ind = SBL_IND_QUIESCENT;
    tx_info_next = SBL_TX_INFO0;
    case (state_reg)
      SBL_ST_DEACT: state_ind = SBL_IND_QUIESCENT;
      SBL_ST_PEND_DEACT: state_ind = pend_ind_reg;
      SBL_ST_PWR_UP: state_ind = SBL_IND_CLOCKS_RUNNING;
      SBL_ST_PEND_ACT: begin
        state_ind = SBL_IND_CLOCKS_RUNNING;
        tx_info_next = SBL_TX_INFO1;
      end
      SBL_ST_UNSYNC, SBL_ST_LOST_FRAME: state_ind = SBL_IND_UNSYNC;
      SBL_ST_SYNCED: begin
        state_ind = SBL_IND_INFO2_SEEN;
        tx_info_next = SBL_TX_INFO3;
      end
      SBL_ST_ACTIVE: begin
        state_ind = prio10_reg ? SBL_IND_ACTIVE_PRIO10 : SBL_IND_ACTIVE_PRIO8;
        tx_info_next = SBL_TX_INFO3;
      end
      SBL_ST_LOOP_CLOSED: begin
        state_ind = SBL_IND_LOOP_CLOSED;
        tx_info_next = SBL_TX_INFO3;
      end
      SBL_ST_LOOP_ACTIVE: begin
        state_ind = (loop_internal && line_awake) ? SBL_IND_UNSYNC : SBL_IND_LOOP_ACTIVE;
        tx_info_next = SBL_TX_INFO3;
      end
      SBL_ST_TEST_SINGLE: begin
        state_ind = SBL_IND_TEST_ACK;
        tx_info_next = SBL_TX_SINGLE;
      end
      SBL_ST_TEST_CONT: begin
        state_ind = SBL_IND_TEST_ACK;
        tx_info_next = SBL_TX_CONT;
      end
      SBL_ST_RESTART: state_ind = SBL_IND_RESTART_ACK;
      default: state_ind = SBL_IND_QUIESCENT;
    endcase
  end
  assign state_change = (state_next != state_reg);
  // violation report, held until the state moves
  assign cvr_next = state_change ? 1'b0
                  : (cvr_reg || (illegal_violation_enable && rx_code_violation));
  assign ci_ind_next = cvr_reg ? SBL_IND_BAD_VIOLATION : state_ind;
  wire logic ind_changed = (ci_ind_next != ci_ind_reg);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= SBL_ST_DEACT;
      pend_ind_reg <= SBL_IND_REMOTE_DEACT;
      prio10_reg <= 1'b0;
      cvr_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pend_ind_reg <= pend_ind_next;
      prio10_reg <= prio10_next;
      cvr_reg <= cvr_next;
    end
  end
  // indication register and sticky change flag, set beats clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ci_ind_reg <= SBL_IND_RESET;
      ci_change_irq <= 1'b0;
      irq_status_reg <= 1'b0;
    end else begin
      ci_ind_reg <= ci_ind_next;
      ci_change_irq <= ind_changed;
      irq_status_reg <= ind_changed || (irq_status_reg && !irq_clear);
    end
  end
  // clock stop timer; restarts on every entry to deactivated
  wire logic stop_arm = (state_reg == SBL_ST_DEACT) && rx_info0 && !clock_stop_cfg &&
                        !software_layer1_select;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stop_cnt_reg <= '0;
      stopped_reg <= 1'b0;
    end else if (!stop_arm || state_change) begin
      stop_cnt_reg <= '0;
      stopped_reg <= stopped_reg && (state_reg == SBL_ST_DEACT) && !state_change;
    end else if (stop_cnt_reg == STOP_LAST) begin
      stopped_reg <= 1'b1;
    end else begin
      stop_cnt_reg <= stop_cnt_reg + 1'b1;
    end
  end
  assign clocks_run = !stopped_reg;
  assign analog_sleep_bit = stopped_reg;
  // wake pattern and frame bit counter
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pat_idx_reg <= 3'h7;
      bit_cnt_reg <= '0;
    end else if (bit_tick) begin
      pat_idx_reg <= pat_idx_reg - 1'b1;
      bit_cnt_reg <= (bit_cnt_reg == FRAME_LAST) ? 6'h00 : bit_cnt_reg + 1'b1;
    end
  end
  // alternating pulses: one per frame or one every bit
  wire logic pulse_due = bit_tick && ((tx_info == SBL_TX_CONT) ||
                         (tx_info == SBL_TX_SINGLE && bit_cnt_reg == 6'h00));
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tx_info <= SBL_TX_INFO0;
      tx_data_bit <= 1'b0;
      tx_pulse <= 1'b0;
      tx_pulse_neg <= 1'b0;
      loop_a_close <= 1'b0;
      transparent_en <= 1'b0;
      xcvr_status_reg <= 4'h0;
    end else begin
      tx_info <= software_layer1_select ? xcvr_command_reg : tx_info_next;
      tx_data_bit <= (tx_info == SBL_TX_INFO1) ? SBL_INFO1_PATTERN[pat_idx_reg] : 1'b0;
      tx_pulse <= pulse_due || (tx_pulse && !bit_tick);
      tx_pulse_neg <= tx_pulse_neg ^ pulse_due;
      loop_a_close <= in_loop;
      transparent_en <= frame_locked_flag &&
                        ((state_reg == SBL_ST_ACTIVE && cmd_ar) ||
                         (state_reg == SBL_ST_LOOP_ACTIVE && ci_cmd_reg == SBL_CMD_LOOP_ACT));
      xcvr_status_reg <= {frame_locked_flag, rx_info4, rx_info2, rx_info0};
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_deact_quiescent: assert property (
    state_reg == SBL_ST_DEACT && !cvr_reg |=> ci_ind_reg == SBL_IND_QUIESCENT
      && tx_info == ($past(software_layer1_select) ? $past(xcvr_command_reg) : SBL_TX_INFO0))
    else $error("deactivated state not quiescent");
  a_wake_powerup: assert property (
    state_reg == SBL_ST_DEACT && cmd_wake && !software_layer1_select && !(rx_info2 || rx_info4 ||
    rx_infox) |=> state_reg == SBL_ST_PWR_UP ##1 ci_ind_reg == SBL_IND_CLOCKS_RUNNING)
    else $error("clock wake did not reach power up");
  a_act_request: assert property (
    state_reg == SBL_ST_DEACT && cmd_ar && !software_layer1_select && !rx_info2 &&
    !rx_info4 && !rx_infox |=> state_reg == SBL_ST_PEND_ACT)
    else $error("activation request ignored");
  a_sync_ind: assert property (
    state_reg == SBL_ST_SYNCED && !cvr_reg |=> ci_ind_reg == SBL_IND_INFO2_SEEN)
    else $error("synchronized indication wrong");
  a_transp_gate: assert property (
    transparent_en |-> $past(frame_locked_flag) && ($past(cmd_ar) ||
    $past(ci_cmd_reg) == SBL_CMD_LOOP_ACT))
    else $error("transparency without request and lock");
  a_pend_hold: assert property (
    state_reg == SBL_ST_PEND_DEACT && !cmd_di && !cmd_uncond && !software_layer1_select
    |=> state_reg == SBL_ST_PEND_DEACT)
    else $error("pending deactivation left without command");
  a_stop_time: assert property (
    $rose(stopped_reg) |-> $past(stop_arm) && $past(stop_cnt_reg) == STOP_LAST)
    else $error("clocks stopped at wrong time");
  a_deact_code: assert property (
    state_reg == SBL_ST_SYNCED && rx_info0 && !uncond_hit && !software_layer1_select
    |=> pend_ind_reg == SBL_IND_DEACT_FROM_SYNC)
    else $error("deactivation code from synchronized wrong");
  a_irq_change: assert property (
    ci_change_irq |-> ci_ind_reg != $past(ci_ind_reg))
    else $error("change interrupt without change");
  a_cvr_gate: assert property (
    $rose(cvr_reg) |-> $past(illegal_violation_enable) && $past(rx_code_violation))
    else $error("violation reported while disabled");

  c_activate: cover property (state_reg == SBL_ST_PEND_ACT ##[1:20] state_reg == SBL_ST_ACTIVE);
  c_loop: cover property (state_reg == SBL_ST_LOOP_CLOSED ##1 state_reg == SBL_ST_LOOP_ACTIVE);
  c_clock_stop: cover property ($rose(stopped_reg));
  c_remote_deact: cover property (state_reg == SBL_ST_ACTIVE ##1 state_reg == SBL_ST_PEND_DEACT);
endmodule : sbl_layer1_fsm
`default_nettype wire

// ===== hw/sbl_pkg.sv
// Shared constants for the S-bus layer-1 activation state machine
package sbl_pkg;
  // Command codes on the C/I channel
  localparam logic [3:0] SBL_CMD_CLOCK_WAKE = 4'h0;
  localparam logic [3:0] SBL_CMD_RESTART = 4'h1;
  localparam logic [3:0] SBL_CMD_SINGLE_PULSE = 4'h2;
  localparam logic [3:0] SBL_CMD_CONT_PULSE = 4'h3;
  localparam logic [3:0] SBL_CMD_ACT_PRIO8 = 4'h8;
  localparam logic [3:0] SBL_CMD_ACT_PRIO10 = 4'h9;
  localparam logic [3:0] SBL_CMD_LOOP_ACT = 4'hA;
  localparam logic [3:0] SBL_CMD_DEACT_IND = 4'hF;
  // Indication codes on the C/I channel
  localparam logic [3:0] SBL_IND_REMOTE_DEACT = 4'h0;
  localparam logic [3:0] SBL_IND_RESTART_ACK = 4'h1;
  localparam logic [3:0] SBL_IND_TEST_ACK = 4'h2;
  localparam logic [3:0] SBL_IND_UNSYNC = 4'h4;
  localparam logic [3:0] SBL_IND_DEACT_FROM_SYNC = 4'h5;
  localparam logic [3:0] SBL_IND_CLOCKS_RUNNING = 4'h7;
  localparam logic [3:0] SBL_IND_INFO2_SEEN = 4'h8;
  localparam logic [3:0] SBL_IND_LOOP_CLOSED = 4'hA;
  localparam logic [3:0] SBL_IND_BAD_VIOLATION = 4'hB;
  localparam logic [3:0] SBL_IND_ACTIVE_PRIO8 = 4'hC;
  localparam logic [3:0] SBL_IND_ACTIVE_PRIO10 = 4'hD;
  localparam logic [3:0] SBL_IND_LOOP_ACTIVE = 4'hE;
  localparam logic [3:0] SBL_IND_QUIESCENT = 4'hF;
  // Line signal selection driven to the transmitter
  localparam logic [2:0] SBL_TX_INFO0 = 3'h0;
  localparam logic [2:0] SBL_TX_INFO1 = 3'h1;
  localparam logic [2:0] SBL_TX_INFO3 = 3'h3;
  localparam logic [2:0] SBL_TX_SINGLE = 3'h5;
  localparam logic [2:0] SBL_TX_CONT = 3'h6;
  // Repeating upstream wake pattern, sent MSB first
  localparam logic [7:0] SBL_INFO1_PATTERN = 8'h3F;
  localparam int SBL_BITS_PER_FRAME = 48;
  // Clock stop delay
  localparam int SBL_STOP_DELAY_US = 500;
  localparam int SBL_CLK_MHZ = 100;
  localparam int SBL_STOP_CYCLES = SBL_STOP_DELAY_US * SBL_CLK_MHZ;
  localparam logic [3:0] SBL_IND_RESET = 4'hF;
  typedef enum logic [12:0] {
    SBL_ST_DEACT = 13'h0001,
    SBL_ST_PEND_DEACT = 13'h0002,
    SBL_ST_PWR_UP = 13'h0004,
    SBL_ST_PEND_ACT = 13'h0008,
    SBL_ST_UNSYNC = 13'h0010,
    SBL_ST_SYNCED = 13'h0020,
    SBL_ST_ACTIVE = 13'h0040,
    SBL_ST_LOST_FRAME = 13'h0080,
    SBL_ST_LOOP_CLOSED = 13'h0100,
    SBL_ST_LOOP_ACTIVE = 13'h0200,
    SBL_ST_TEST_SINGLE = 13'h0400,
    SBL_ST_TEST_CONT = 13'h0800,
    SBL_ST_RESTART = 13'h1000
  } sbl_state_t;
endpackage : sbl_pkg

// ===== sim/sbl_l2_model.sv
// Layer-2 controller model holding C/I commands as levels
`timescale 1ns/1ps
`default_nettype none
module sbl_l2_model import sbl_pkg::*; (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [3:0] req_code,
  input wire logic req_stb,
  input wire logic [1:0] lag,
  output logic [3:0] ci_cmd_reg
);
  logic [3:0] held_reg;
  logic [1:0] wait_reg;
  logic busy_reg;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ci_cmd_reg <= SBL_CMD_DEACT_IND;
      held_reg <= SBL_CMD_DEACT_IND;
      wait_reg <= 2'h0;
      busy_reg <= 1'h0;
    end else if (req_stb) begin
      held_reg <= req_code;
      wait_reg <= lag;
      busy_reg <= 1'h1;
    end else if (busy_reg && wait_reg != 2'h0) begin
      // Slow answers: lag cycles before the code lands
      wait_reg <= wait_reg - 2'h1;
    end else if (busy_reg) begin
      ci_cmd_reg <= held_reg;
      busy_reg <= 1'h0;
    end
  end
endmodule : sbl_l2_model
`default_nettype wire

// ===== sim/sbl_layer1_fsm_test.sv
// Self-checking bench for the layer-1 activation machine
`timescale 1ns/1ps
`default_nettype none
module sbl_layer1_fsm_test import sbl_pkg::*;;
  localparam int STOP = 20;
  logic mclk, resetn, software_layer1_select, irq_clear, irq_status_reg, ci_change_irq;
  logic rx_info0, rx_info2, rx_info4, rx_infox, frame_locked_flag, rx_code_violation;
  logic line_awake, bit_tick, clock_stop_cfg, illegal_violation_enable, loop_internal;
  logic tx_data_bit, tx_pulse, tx_pulse_neg, loop_a_close, transparent_en, clocks_run;
  logic analog_sleep_bit, req_stb, ok;
  logic [1:0] lag, tick_cnt;
  logic [2:0] xcvr_command_reg, tx_info, pick;
  logic [3:0] xcvr_status_reg, ci_cmd_reg, ci_ind_reg, req_code;
  logic [7:0] s;
  logic [31:0] v;
  logic [2:0] codes [5] = '{SBL_TX_INFO0, SBL_TX_INFO1, SBL_TX_INFO3, SBL_TX_SINGLE, SBL_TX_CONT};
  logic [3:0] exp_q[$];
  int fail_count, checks;
  sbl_layer1_fsm #(.CLOCK_STOP_CYCLES(STOP)) dut_u (.mclk, .resetn, .software_layer1_select,
    .xcvr_command_reg, .xcvr_status_reg, .ci_cmd_reg, .ci_ind_reg, .irq_status_reg, .irq_clear,
    .ci_change_irq, .rx_info0, .rx_info2, .rx_info4, .rx_infox, .frame_locked_flag,
    .rx_code_violation, .line_awake, .bit_tick, .clock_stop_cfg, .illegal_violation_enable,
    .loop_internal, .tx_info, .tx_data_bit, .tx_pulse, .tx_pulse_neg, .loop_a_close,
    .transparent_en, .clocks_run, .analog_sleep_bit);
  sbl_l2_model ctl_u (.mclk, .resetn, .req_code, .req_stb, .lag, .ci_cmd_reg);
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  // One line bit every four cycles
  always @(posedge mclk) begin
    tick_cnt <= tick_cnt + 2'h1;
    bit_tick <= (tick_cnt == 2'h3);
  end
  task automatic bad(input string m);
    fail_count++;
    $display("BAD %0t %s", $time, m);
  endtask : bad
  task automatic chk4(input logic [3:0] got, input logic [3:0] e);
    checks++;
    if (got !== e) bad($sformatf("code %h want %h", got, e));
  endtask : chk4
  task automatic chk1(input logic got, input logic e);
    checks++;
    if (got !== e) bad($sformatf("flag %b want %b", got, e));
  endtask : chk1
  task automatic chkn(input int got, input int e);
    checks++;
    if (got != e) bad($sformatf("count %0d want %0d", got, e));
  endtask : chkn
  task automatic give_verdict;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  // every indication change is predicted and flagged
  always @(negedge mclk) begin
    if (ci_change_irq === 1'h1) begin
      if (exp_q.size() == 0) bad("unexpected indication");
      else chk4(ci_ind_reg, exp_q.pop_front());
      chk1(irq_status_reg, 1'h1);
    end
  end
  task automatic drain;
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    if (exp_q.size() != 0) begin
      bad("indication timeout");
      give_verdict();
    end
    repeat (8) @(posedge mclk);
    irq_clear <= 1'h1;
    @(posedge mclk);
    irq_clear <= 1'h0;
    @(negedge mclk);
    chk1(irq_status_reg, 1'h0);
  endtask : drain
  task automatic cmd(input logic [3:0] c, input logic [3:0] e, input bit has);
    @(posedge mclk);
    req_code <= c;
    req_stb <= 1'h1;
    lag <= 2'($urandom_range(3, 0));
    if (has) exp_q.push_back(e);
    @(posedge mclk);
    req_stb <= 1'h0;
    drain();
  endtask : cmd
  // Bits are {info0, info2, info4, infox, lock}
  task automatic rx_set(input logic [4:0] b, input logic [3:0] e);
    @(posedge mclk);
    {rx_info0, rx_info2, rx_info4, rx_infox, frame_locked_flag} <= b;
    exp_q.push_back(e);
    drain();
  endtask : rx_set
  task automatic pulses(input int want);
    int n, hi;
    logic last;
    n = 0;
    hi = 0;
    last = tx_pulse_neg;
    repeat (384) begin
      @(negedge mclk);
      if (tx_pulse_neg !== last) n++;
      if (tx_pulse === 1'h1) hi++;
      last = tx_pulse_neg;
    end
    chkn(n, want);
    // Each pulse fills one line bit of four cycles
    chkn(hi, want * 4);
  endtask : pulses
  initial begin
    {resetn, software_layer1_select, irq_clear, rx_code_violation, req_stb} = 5'h0;
    {rx_info0, rx_info2, rx_info4, rx_infox, frame_locked_flag, line_awake} = 6'h0;
    {clock_stop_cfg, illegal_violation_enable, loop_internal, bit_tick} = 4'h0;
    {xcvr_command_reg, req_code, lag, tick_cnt} = 11'h0;
    void'($urandom(32'hADBD));
    repeat (16) @(posedge mclk);
    resetn <= 1'h1;
    @(negedge mclk);
    chk4(ci_ind_reg, SBL_IND_QUIESCENT);
    chk4({1'h0, tx_info}, {1'h0, SBL_TX_INFO0});
    // priority 8 activation, teardown, clock stop
    cmd(SBL_CMD_ACT_PRIO8, SBL_IND_CLOCKS_RUNNING, 1);
    chk4({1'h0, tx_info}, {1'h0, SBL_TX_INFO1});
    s = 8'h0;
    repeat (8) begin
      repeat (4) @(negedge mclk);
      s = {s[6:0], tx_data_bit};
    end
    ok = 1'h0;
    for (int r = 0; r < 8; r++) if (((8'h3F << r) | (8'h3F >> (8 - r))) === s) ok = 1'h1;
    chk1(ok, 1'h1);
    rx_set(5'h05, SBL_IND_ACTIVE_PRIO8);
    chk1(transparent_en, 1'h1);
    rx_set(5'h11, SBL_IND_REMOTE_DEACT);
    chk1(transparent_en, 1'h0);
    cmd(SBL_CMD_ACT_PRIO8, 4'h0, 0);
    cmd(SBL_CMD_DEACT_IND, SBL_IND_QUIESCENT, 1);
    chk1(clocks_run, 1'h1);
    repeat (STOP) @(negedge mclk);
    chk1(clocks_run, 1'h0);
    chk1(analog_sleep_bit, 1'h1);
    cmd(SBL_CMD_CLOCK_WAKE, SBL_IND_CLOCKS_RUNNING, 1);
    chk1(clocks_run, 1'h1);
    chk4({1'h0, tx_info}, {1'h0, SBL_TX_INFO0});
    rx_set(5'h09, SBL_IND_INFO2_SEEN);
    chk4({1'h0, tx_info}, {1'h0, SBL_TX_INFO3});
    rx_set(5'h11, SBL_IND_DEACT_FROM_SYNC);
    @(posedge mclk);
    rx_info0 <= 1'h0;
    cmd(SBL_CMD_DEACT_IND, SBL_IND_QUIESCENT, 1);
    cmd(SBL_CMD_ACT_PRIO10, SBL_IND_CLOCKS_RUNNING, 1);
    rx_set(5'h05, SBL_IND_ACTIVE_PRIO10);
    chk1(transparent_en, 1'h1);
    rx_set(5'h04, SBL_IND_UNSYNC);
    chk1(transparent_en, 1'h0);
    rx_set(5'h10, SBL_IND_REMOTE_DEACT);
    @(posedge mclk);
    {rx_info0, frame_locked_flag} <= 2'h1;
    cmd(SBL_CMD_DEACT_IND, SBL_IND_QUIESCENT, 1);
    cmd(SBL_CMD_CLOCK_WAKE, SBL_IND_CLOCKS_RUNNING, 1);
    rx_set(5'h03, SBL_IND_UNSYNC);
    @(posedge mclk);
    rx_infox <= 1'h0;
    cmd(SBL_CMD_DEACT_IND, SBL_IND_QUIESCENT, 1);
    // violation report gated by its enable
    repeat (2) begin
      @(posedge mclk);
      rx_code_violation <= 1'h1;
      if (illegal_violation_enable) exp_q.push_back(SBL_IND_BAD_VIOLATION);
      @(posedge mclk);
      rx_code_violation <= 1'h0;
      drain();
      illegal_violation_enable <= 1'h1;
    end
    cmd(SBL_CMD_CLOCK_WAKE, SBL_IND_CLOCKS_RUNNING, 1);
    illegal_violation_enable <= 1'h0;
    // internal loop; controller mutes transmitter, seen here as loop_internal
    {loop_internal, frame_locked_flag} <= 2'h2;
    cmd(SBL_CMD_LOOP_ACT, SBL_IND_LOOP_CLOSED, 1);
    chk1(loop_a_close, 1'h1);
    chk4({1'h0, tx_info}, {1'h0, SBL_TX_INFO3});
    rx_set(5'h01, SBL_IND_LOOP_ACTIVE);
    @(posedge mclk);
    line_awake <= 1'h1;
    exp_q.push_back(SBL_IND_UNSYNC);
    drain();
    cmd(SBL_CMD_DEACT_IND, SBL_IND_QUIESCENT, 1);
    {line_awake, loop_internal} <= 2'h0;
    cmd(SBL_CMD_SINGLE_PULSE, SBL_IND_TEST_ACK, 1);
    chk4({1'h0, tx_info}, {1'h0, SBL_TX_SINGLE});
    pulses(2);
    cmd(SBL_CMD_DEACT_IND, SBL_IND_QUIESCENT, 1);
    cmd(SBL_CMD_CONT_PULSE, SBL_IND_TEST_ACK, 1);
    chk4({1'h0, tx_info}, {1'h0, SBL_TX_CONT});
    pulses(96);
    cmd(SBL_CMD_DEACT_IND, SBL_IND_QUIESCENT, 1);
    cmd(SBL_CMD_ACT_PRIO8, SBL_IND_CLOCKS_RUNNING, 1);
    cmd(SBL_CMD_RESTART, SBL_IND_RESTART_ACK, 1);
    chk4({1'h0, tx_info}, {1'h0, SBL_TX_INFO0});
    cmd(SBL_CMD_DEACT_IND, SBL_IND_QUIESCENT, 1);
    // clock stop held off by its configuration bit
    @(posedge mclk);
    {clock_stop_cfg, rx_info0} <= 2'h3;
    repeat (STOP + 4) @(negedge mclk);
    chk1(clocks_run, 1'h1);
    chk1(analog_sleep_bit, 1'h0);
    @(posedge mclk);
    {clock_stop_cfg, rx_info0} <= 2'h0;
    software_layer1_select <= 1'h1;
    repeat (6) begin
      @(posedge mclk);
      v = $urandom;
      pick = codes[v[2:0] % 5];
      xcvr_command_reg <= pick;
      {frame_locked_flag, rx_info4, rx_info2, rx_info0} <= v[7:4];
      repeat (3) @(negedge mclk);
      chk4({1'h0, tx_info}, {1'h0, pick});
      chk4(xcvr_status_reg, v[7:4]);
    end
    cmd(SBL_CMD_ACT_PRIO8, 4'h0, 0);
    cmd(SBL_CMD_DEACT_IND, 4'h0, 0);
    {frame_locked_flag, rx_info4, rx_info2, rx_info0} <= 4'h0;
    @(posedge mclk);
    software_layer1_select <= 1'h0;
    repeat (10) @(posedge mclk);
    give_verdict();
  end
endmodule : sbl_layer1_fsm_test
`default_nettype wire
